// file: rtl/mpgc_pkg.sv
// Constants for the module power gating control block
package mpgc_pkg;

  // Register geometry
  localparam int unsigned REG_W = 16;

  // Control bit positions of module_power_control
  localparam int unsigned BIT_AUTO      = 0;
  localparam int unsigned BIT_VREF_REST = 1;
  localparam int unsigned BIT_SPINDLE   = 2;
  localparam int unsigned BIT_ACT_DAC   = 3;
  localparam int unsigned BIT_MUX_AMP   = 4;
  localparam int unsigned BIT_LADDER    = 5;
  localparam int unsigned BIT_ADC       = 6;
  localparam int unsigned BIT_SEQ       = 7;
  localparam int unsigned BIT_SERIAL    = 8;
  localparam int unsigned BIT_OSC_PD    = 9;
  localparam int unsigned BIT_SYSTEM_CLOCK_OUTPUT_PIN    = 10;
  localparam int unsigned BIT_AUX_DIV   = 11;
  localparam int unsigned BIT_OSC_START = 12;

  // Reset value and writable bit mask
  localparam logic [15:0] RESET_VALUE   = 16'hffff;
  localparam logic [15:0] WRITE_MASK    = 16'h1fff;
  localparam logic [15:0] RESERVED_ONES = 16'he000;

  // Number of always-on peripherals powered by activity alone
  localparam int unsigned N_ACTIVITY = 3;

  // Oscillator run state
  typedef enum logic {
    MPGC_OSC_RUNNING,
    MPGC_OSC_HALTED
  } mpgc_osc_state_t;

endpackage : mpgc_pkg

// file: rtl/mpgc_bits_if.sv
// Carrier between the top module and its control bit store
`timescale 1ns/100ps
`default_nettype none

interface mpgc_bits_if #(
  parameter int unsigned W = 16
);
  logic         ce;     // Clock enable
  logic         wr;     // Software write strobe
  logic [W-1:0] wdata;  // Software write data
  logic [W-1:0] wmask;  // Bits that software may write
  logic [W-1:0] wake;   // Hardware set requests
  logic [W-1:0] q;      // Stored bits

  modport store (input ce, wr, wdata, wmask, wake, output q);
  modport ctrl  (output ce, wr, wdata, wmask, wake, input q);
endinterface : mpgc_bits_if

`default_nettype wire

// file: rtl/mpgc_ctl_bits.sv
// Control bit store: reset to one, software write, hardware set
`timescale 1ns/100ps
`default_nettype none

module mpgc_ctl_bits #(
  parameter int unsigned          W         = 16,
  parameter logic [W-1:0]         RESET_VAL = '1
) (
  input  wire logic    clk_i,  // Block clock
  input  wire logic    rst_n_i,  // Asynchronous reset, active low
  mpgc_bits_if.store   bits  // Write and wake requests, stored bits
);

  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  // Write updates writable bits; a wake set beats a same-cycle clear
  always_comb begin
    q_next = q_reg;
    if (bits.wr) begin
      q_next = (q_reg & ~bits.wmask) | (bits.wdata & bits.wmask);
    end
    q_next = q_next | bits.wake;
  end

  // Every bit comes up set so all register-controlled modules run after reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_reg <= RESET_VAL;
    end else if (bits.ce) begin
      q_reg <= q_next;
    end
  end

  assign bits.q = q_reg;

endmodule : mpgc_ctl_bits

`default_nettype wire

// file: rtl/mpgc_top.sv
// Module power gating control: power control register and gate enables
//
// Operation
// - One register; set bit powers, clear sleeps
// - Static mode: each bit gates its module
// - Auto mode wakes on search alone
// - Start-up bit zero gates oscillator by ready
// - Bit gates clock into auxiliary divider
// - Bit gates oscillator onto system clock pin
// - Power-down bit clear plus stop halts oscillator
// - Serial clock continuous, else only when busy
// - Serial wakes on RX edge, transmit write
// - Sequencer bit sleeps sequencers, acquisition keeps running
// - Sequencer wakes on bit, reset, search
// - A/D power follows bit, search wakes
// - Ladder bit keeps ladder on, else follows
// - Ladder wakes on bit, reset, request
// - Mux and amplifier power follow their bit
// - Actuator DAC and shock bias follow bit
// - Timers, diag port, host: activity only
// - Auto bit clear stops servo clocks, A/D
// - Spindle bit powers spindle DAC and logic
`timescale 1ns/100ps
`default_nettype none

module mpgc_top (
  input  wire logic        REF_CLK_I,           // Bus clock, 100 MHz
  input  wire logic        RST_N_I,             // Asynchronous reset, active low
  input  wire logic        CE_I,                // Clock enable, freezes state when low
  input  wire logic        PWR_WR_I,            // DSP write strobe to the register
  input  wire logic [15:0] PWR_WDATA_I,         // DSP write data
  output logic      [15:0] PWR_RDATA_O,         // Register read-back
  input  wire logic        OSC_READY_I,         // Internal oscillator ready indication
  input  wire logic        DSP_STOP_I,          // Stop flag of dsp_status_word_zero
  input  wire logic        EXT_IRQ_I,           // External interrupt, restarts oscillator
  input  wire logic        SERVO_SEARCH_I,      // servo_search level
  input  wire logic        LADDER_PON_REQ_I,    // ladder_power_on_request level
  input  wire logic        SERIAL_RX_I,         // Serial receive line
  input  wire logic        SERIAL_TX_WRITE_I,   // Transmit register write pulse
  input  wire logic        SERIAL_BUSY_I,       // Transmit or receive in progress
  input  wire logic [2:0]  ACTIVITY_I,          // Timers, diag port, host in use
  output logic             OSC_TO_LOGIC_EN_O,   // Oscillator passes to internal logic
  output logic             OSC_RUN_O,           // Master oscillator running
  output logic             AUX_DIV_CLK_EN_O,    // Clock enable into aux_divided_clock divider
  output logic             SYSTEM_CLOCK_OUTPUT_PIN_PIN_EN_O,     // Oscillator onto system_clock_output_pin
  output logic             SERIAL_CLK_EN_O,     // Serial port module clock enable
  output logic             SEQ_CLK_EN_O,        // Burst/timing mark sequencer, data sync clock
  output logic             BURST_DEC_CLK_EN_O,  // Burst decoder clock enable
  output logic             ACQ_CLK_EN_O,        // Data acquisition section clock enable
  output logic             ADC_PWR_O,           // A/D converter power
  output logic             LADDER_PWR_O,        // A/D ladder and buffers power
  output logic             MUX_AMP_PWR_O,       // Front-end mux and channel five amp power
  output logic             ACT_DAC_PWR_O,       // actuator_dac and shock sensor bias power
  output logic             SPINDLE_PWR_O,       // spindle_motor_dac and spindle logic power
  output logic             VREF_REST_PWR_O,     // Voltage reference and remaining logic
  output logic      [2:0]  ACTIVITY_CLK_EN_O    // Clock enables for activity-powered units
);

  localparam int unsigned W = mpgc_pkg::REG_W;

  // Carrier to the bit store
  mpgc_bits_if #(.W(W)) bits_if ();

  // Previous samples for edge detection on wake sources
  logic        search_d_reg;
  logic        ladder_req_d_reg;
  logic        rx_d_reg;

  // Wake events, one cycle each
  logic        search_rise;
  logic        ladder_rise;
  logic        rx_edge;
  logic [W-1:0] wake_vec;

  // Oscillator halt state
  mpgc_pkg::mpgc_osc_state_t osc_state_reg;
  mpgc_pkg::mpgc_osc_state_t osc_state_next;

  // Stored control bits, named by function
  logic [W-1:0] ctl;
  logic        auto_on;
  logic        adc_on;

  // Edge detectors; inputs are already synchronous to the clock
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      search_d_reg     <= 1'b0;
      ladder_req_d_reg <= 1'b0;
      rx_d_reg         <= 1'b1;
    end else if (CE_I) begin
      search_d_reg     <= SERVO_SEARCH_I;
      ladder_req_d_reg <= LADDER_PON_REQ_I;
      rx_d_reg         <= SERIAL_RX_I;
    end
  end

  // Only a rising search or ladder request wakes, so a stuck-high level cannot block sleep; RX wakes on either edge
  assign search_rise = SERVO_SEARCH_I & ~search_d_reg;
  assign ladder_rise = LADDER_PON_REQ_I & ~ladder_req_d_reg;
  assign rx_edge     = SERIAL_RX_I ^ rx_d_reg;

  // Hardware wake requests; each sets its control bit
  always_comb begin
    wake_vec = '0;
    // Search restarts sequencer, A/D and auto servo clocks
    wake_vec[mpgc_pkg::BIT_SEQ]    = search_rise;
    wake_vec[mpgc_pkg::BIT_ADC]    = search_rise;
    wake_vec[mpgc_pkg::BIT_AUTO]   = search_rise;
    // Ladder request wakes the ladder alone
    wake_vec[mpgc_pkg::BIT_LADDER] = ladder_rise;
    // Serial port leaves standby on line activity or a transmit write
    wake_vec[mpgc_pkg::BIT_SERIAL] = rx_edge | SERIAL_TX_WRITE_I;
  end

  // Drive the bit store; reserved upper bits are not writable
  assign bits_if.ce    = CE_I;
  assign bits_if.wr    = PWR_WR_I;
  assign bits_if.wdata = PWR_WDATA_I;
  assign bits_if.wmask = mpgc_pkg::WRITE_MASK;
  assign bits_if.wake  = wake_vec;

  // Control/status register, reset to all ones
  mpgc_ctl_bits #(
    .W         (W),
    .RESET_VAL (mpgc_pkg::RESET_VALUE)
  ) u_bits (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RST_N_I),
    .bits    (bits_if.store)
  );

  assign ctl = bits_if.q;

  // Read-back: stored bits with reserved bits forced to one
  assign PWR_RDATA_O = ctl | mpgc_pkg::RESERVED_ONES;

  // Auto bit scopes the servo processing clocks and A/D
  assign auto_on = ctl[mpgc_pkg::BIT_AUTO];
  assign adc_on  = ctl[mpgc_pkg::BIT_ADC] & auto_on;

  // Oscillator halt: power-down bit cleared and DSP stop requested
  always_comb begin
    osc_state_next = osc_state_reg;
    unique case (osc_state_reg)
      mpgc_pkg::MPGC_OSC_RUNNING: begin
        if (!ctl[mpgc_pkg::BIT_OSC_PD] && DSP_STOP_I) begin
          osc_state_next = mpgc_pkg::MPGC_OSC_HALTED;
        end
      end
      mpgc_pkg::MPGC_OSC_HALTED: begin
        // Only an external interrupt or reset restarts it; writes cannot
        if (EXT_IRQ_I) begin
          osc_state_next = mpgc_pkg::MPGC_OSC_RUNNING;
        end
      end
    endcase
  end

  // Oscillator state register; reset always restarts
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      osc_state_reg <= mpgc_pkg::MPGC_OSC_RUNNING;
    end else if (CE_I) begin
      osc_state_reg <= osc_state_next;
    end
  end

  // Oscillator run flag, taken from the next halt state
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      OSC_RUN_O <= 1'b1;
    end else if (CE_I) begin
      OSC_RUN_O <= (osc_state_next == mpgc_pkg::MPGC_OSC_RUNNING);
    end
  end

  // Start-up bit low: wait for ready; high: bypass the gate
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      OSC_TO_LOGIC_EN_O <= 1'b1;
    end else if (CE_I) begin
      OSC_TO_LOGIC_EN_O <= ctl[mpgc_pkg::BIT_OSC_START] | OSC_READY_I;
    end
  end

  // Clock into the aux_divided_clock divider
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      AUX_DIV_CLK_EN_O <= 1'b1;
    end else if (CE_I) begin
      AUX_DIV_CLK_EN_O <= ctl[mpgc_pkg::BIT_AUX_DIV];
    end
  end

  // Oscillator onto the system_clock_output_pin
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SYSTEM_CLOCK_OUTPUT_PIN_PIN_EN_O <= 1'b1;
    end else if (CE_I) begin
      SYSTEM_CLOCK_OUTPUT_PIN_PIN_EN_O <= ctl[mpgc_pkg::BIT_SYSTEM_CLOCK_OUTPUT_PIN];
    end
  end

  // Serial port clock: free running, or only while a transfer runs
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SERIAL_CLK_EN_O <= 1'b1;
    end else if (CE_I) begin
      SERIAL_CLK_EN_O <= ctl[mpgc_pkg::BIT_SERIAL] | SERIAL_BUSY_I;
    end
  end

  // Sequencer and data sync clock
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SEQ_CLK_EN_O <= 1'b1;
    end else if (CE_I) begin
      SEQ_CLK_EN_O <= ctl[mpgc_pkg::BIT_SEQ] & auto_on;
    end
  end

  // Burst decoder clock, same scope as the sequencer
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      BURST_DEC_CLK_EN_O <= 1'b1;
    end else if (CE_I) begin
      BURST_DEC_CLK_EN_O <= ctl[mpgc_pkg::BIT_SEQ] & auto_on;
    end
  end

  // Acquisition ignores the sequencer bit so sampling goes on
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ACQ_CLK_EN_O <= 1'b1;
    end else if (CE_I) begin
      ACQ_CLK_EN_O <= auto_on;
    end
  end

  // A/D converter power, scoped by the auto bit
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ADC_PWR_O <= 1'b1;
    end else if (CE_I) begin
      ADC_PWR_O <= adc_on;
    end
  end

  // Ladder outlives the A/D when held, as it settles slowly
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      LADDER_PWR_O <= 1'b1;
    end else if (CE_I) begin
      LADDER_PWR_O <= ctl[mpgc_pkg::BIT_LADDER] | adc_on;
    end
  end

  // Front-end mux and amplifier; no hardware wake
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      MUX_AMP_PWR_O <= 1'b1;
    end else if (CE_I) begin
      MUX_AMP_PWR_O <= ctl[mpgc_pkg::BIT_MUX_AMP];
    end
  end

  // Actuator DAC and shock bias; no hardware wake
  // Shared bias: software must keep spindle on for this DAC
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ACT_DAC_PWR_O <= 1'b1;
    end else if (CE_I) begin
      ACT_DAC_PWR_O <= ctl[mpgc_pkg::BIT_ACT_DAC];
    end
  end

  // Spindle DAC and spindle logic; no hardware wake
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      SPINDLE_PWR_O <= 1'b1;
    end else if (CE_I) begin
      SPINDLE_PWR_O <= ctl[mpgc_pkg::BIT_SPINDLE];
    end
  end

  // Reference and remaining logic; no hardware wake
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      VREF_REST_PWR_O <= 1'b1;
    end else if (CE_I) begin
      VREF_REST_PWR_O <= ctl[mpgc_pkg::BIT_VREF_REST];
    end
  end

  // Timers, diag port, host: clocked only while in use
  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ACTIVITY_CLK_EN_O <= 3'h0;
    end else if (CE_I) begin
      ACTIVITY_CLK_EN_O <= ACTIVITY_I;
    end
  end

endmodule : mpgc_top

`default_nettype wire

// file: test/mpgc_assertions.sv
// Port-level checker for the module power gating control block
`timescale 1ns/100ps
`default_nettype none

module mpgc_assertions (
  input wire logic        REF_CLK_I,          // Clock
  input wire logic        RST_N_I,            // Reset
  input wire logic        CE_I,               // Enable
  input wire logic        PWR_WR_I,           // Write
  input wire logic [15:0] PWR_WDATA_I,        // Data in
  input wire logic [15:0] PWR_RDATA_O,        // Read-back
  input wire logic        OSC_READY_I,        // Osc ready
  input wire logic        DSP_STOP_I,         // Stop flag
  input wire logic        EXT_IRQ_I,          // Interrupt
  input wire logic        SERVO_SEARCH_I,     // Search
  input wire logic        LADDER_PON_REQ_I,   // Ladder request
  input wire logic        SERIAL_TX_WRITE_I,  // Tx write
  input wire logic        SERIAL_BUSY_I,      // Serial busy
  input wire logic        OSC_TO_LOGIC_EN_O,  // Osc gate
  input wire logic        OSC_RUN_O,          // Osc running
  input wire logic        AUX_DIV_CLK_EN_O,   // Aux clock
  input wire logic        SERIAL_CLK_EN_O,    // Serial clock
  input wire logic        SEQ_CLK_EN_O,       // Sequencer clock
  input wire logic        ACQ_CLK_EN_O,       // Acquisition clock
  input wire logic        ADC_PWR_O,          // A/D power
  input wire logic        LADDER_PWR_O        // Ladder power
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  // A search or ladder rise counts only after an enabled edge; an aux clear write needs the next edge enabled too
  sequence s_aux_clear;
    RST_N_I && CE_I && PWR_WR_I && !PWR_WDATA_I[11] ##1 CE_I;
  endsequence
  sequence s_seen(sig);
    $past(CE_I) && CE_I && $rose(sig);
  endsequence

  a_reserved_ones: assert property (PWR_RDATA_O[15:13] == 3'h7) else $error("reserved bits not one");
  a_write_takes: assert property (RST_N_I && CE_I && PWR_WR_I |=> PWR_RDATA_O[12:9] == $past(PWR_WDATA_I[12:9])
    && PWR_RDATA_O[4:1] == $past(PWR_WDATA_I[4:1])) else $error("write not stored");
  a_search_wakes: assert property (s_seen(SERVO_SEARCH_I) |=> PWR_RDATA_O[7] && PWR_RDATA_O[6]
    && PWR_RDATA_O[0]) else $error("search did not wake");
  a_ladder_wakes: assert property (s_seen(LADDER_PON_REQ_I) |=> PWR_RDATA_O[5]) else $error("no ladder wake");
  a_serial_wakes: assert property (CE_I && SERIAL_TX_WRITE_I |=> PWR_RDATA_O[8]) else $error("no serial wake");
  a_aux_sleep: assert property (s_aux_clear |=> !AUX_DIV_CLK_EN_O) else $error("aux clock kept");
  a_servo_gates: assert property (CE_I |=> ACQ_CLK_EN_O == $past(PWR_RDATA_O[0])
    && SEQ_CLK_EN_O == $past(PWR_RDATA_O[7] & PWR_RDATA_O[0])
    && ADC_PWR_O == $past(PWR_RDATA_O[6] & PWR_RDATA_O[0])) else $error("servo gates wrong");
  a_ladder_follow: assert property (CE_I |=> LADDER_PWR_O == $past(PWR_RDATA_O[5]
    | (PWR_RDATA_O[6] & PWR_RDATA_O[0]))) else $error("ladder power wrong");
  a_serial_clk: assert property (CE_I |=> SERIAL_CLK_EN_O == $past(PWR_RDATA_O[8] | SERIAL_BUSY_I))
    else $error("serial clock wrong");
  a_osc_gate: assert property (CE_I |=> OSC_TO_LOGIC_EN_O == $past(PWR_RDATA_O[12] | OSC_READY_I))
    else $error("osc gate wrong");
  a_osc_halt: assert property (CE_I && !PWR_RDATA_O[9] && DSP_STOP_I && !EXT_IRQ_I |=> !OSC_RUN_O)
    else $error("osc not halted");
  a_osc_held: assert property (!OSC_RUN_O && !EXT_IRQ_I |=> !OSC_RUN_O) else $error("osc restarted");
endmodule : mpgc_assertions

bind mpgc_top mpgc_assertions u_chk (.REF_CLK_I, .RST_N_I, .CE_I, .PWR_WR_I, .PWR_WDATA_I, .PWR_RDATA_O,
  .OSC_READY_I, .DSP_STOP_I, .EXT_IRQ_I, .SERVO_SEARCH_I, .LADDER_PON_REQ_I, .SERIAL_TX_WRITE_I,
  .SERIAL_BUSY_I, .OSC_TO_LOGIC_EN_O, .OSC_RUN_O, .AUX_DIV_CLK_EN_O, .SERIAL_CLK_EN_O, .SEQ_CLK_EN_O,
  .ACQ_CLK_EN_O, .ADC_PWR_O, .LADDER_PWR_O);

`default_nettype wire

// file: test/module_power_gating_control_tb.sv
// Self-checking bench for the module power gating control block
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected %0t output differs from model", $time); end end

module module_power_gating_control_tb;
  logic        clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr = 1'b0, ready = 1'b0, stop = 1'b0, irq = 1'b0;
  logic        servo_search = 1'b0, lpon = 1'b0, rx = 1'b1, txw = 1'b0, busy = 1'b0, run, m_run;
  logic        p_servo_search, p_lpon, p_rx;
  logic [15:0] wdata = 16'h0000, rdata, m_reg, wake;
  logic [2:0]  act = 3'h0, act_en, m_act;
  logic [12:0] outs, m_outs;
  int          bad_count = 0;
  int          n_checks = 0;
  int          seed = 19;
  int          r;

  // Expected gate outputs from a register value
  function automatic logic [12:0] gates(input logic [15:0] g, input logic rdy, input logic bsy);
    return {g[12] | rdy, g[11], g[10], g[8] | bsy, g[7] & g[0], g[7] & g[0], g[0], g[6] & g[0],
            g[5] | (g[6] & g[0]), g[4], g[3], g[2], g[1]};
  endfunction : gates

  always #5 clk = ~clk;

  mpgc_top DUT (.REF_CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .PWR_WR_I(wr), .PWR_WDATA_I(wdata),
    .PWR_RDATA_O(rdata), .OSC_READY_I(ready), .DSP_STOP_I(stop), .EXT_IRQ_I(irq), .SERVO_SEARCH_I(servo_search),
    .LADDER_PON_REQ_I(lpon), .SERIAL_RX_I(rx), .SERIAL_TX_WRITE_I(txw), .SERIAL_BUSY_I(busy),
    .ACTIVITY_I(act), .OSC_TO_LOGIC_EN_O(outs[12]), .OSC_RUN_O(run), .AUX_DIV_CLK_EN_O(outs[11]),
    .SYSTEM_CLOCK_OUTPUT_PIN_PIN_EN_O(outs[10]), .SERIAL_CLK_EN_O(outs[9]), .SEQ_CLK_EN_O(outs[8]),
    .BURST_DEC_CLK_EN_O(outs[7]), .ACQ_CLK_EN_O(outs[6]), .ADC_PWR_O(outs[5]), .LADDER_PWR_O(outs[4]),
    .MUX_AMP_PWR_O(outs[3]), .ACT_DAC_PWR_O(outs[2]), .SPINDLE_PWR_O(outs[1]),
    .VREF_REST_PWR_O(outs[0]), .ACTIVITY_CLK_EN_O(act_en));

  // Hardware wake requests seen at this edge; set wins over a write
  assign wake = (servo_search && !p_servo_search ? 16'h00c1 : 16'h0000) | (lpon && !p_lpon ? 16'h0020 : 16'h0000)
              | ((rx != p_rx) || txw ? 16'h0100 : 16'h0000);

  // Reference model, frozen with the enable like the design
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      m_reg <= 16'hffff;
      m_outs <= 13'h1fff;
      {m_act, m_run, p_servo_search, p_lpon, p_rx} <= 7'h09;
    end else if (ce) begin
      m_reg <= (wr ? {3'h7, wdata[12:0]} : m_reg) | wake;
      m_outs <= gates(m_reg, ready, busy);
      m_act <= act;
      m_run <= m_run ? !(stop && !m_reg[9]) : irq;
      {p_servo_search, p_lpon, p_rx} <= {servo_search, lpon, rx};
    end
  end

  // Compare on the falling edge, away from updates
  always @(negedge clk) begin
    `CHK(rdata, m_reg)
    `CHK(outs[12:9], m_outs[12:9])
    `CHK(outs[8:4], m_outs[8:4])
    `CHK(outs[3:0], m_outs[3:0])
    `CHK({run, act_en}, {m_run, m_act})
  end

  // One random cycle; writes keep the spindle DAC up under the actuator DAC
  task automatic rand_cycle();
    int w;
    @(posedge clk);
    r = $random(seed);
    w = $random(seed);
    ce <= r[2:0] != 3'h0;
    wr <= r[4:3] == 2'h0;
    wdata <= {w[15:4], w[3], w[2] | w[3], w[1:0]};
    {ready, busy, act} <= r[9:5];
    servo_search <= servo_search ^ (r[12:10] == 3'h0);
    lpon <= lpon ^ (r[15:13] == 3'h0);
    rx <= rx ^ (r[18:16] == 3'h0);
    txw <= r[21:19] == 3'h0;
    stop <= r[24:22] == 3'h0;
    irq <= r[27:25] == 3'h0;
  endtask : rand_cycle

  task automatic complete_run();
    if (bad_count == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // Corners first: all off with halt, then a clearing write racing a ladder wake
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk) begin wr <= 1'b1; stop <= 1'b1; end
    @(posedge clk) wr <= 1'b0;
    @(posedge clk) begin stop <= 1'b0; servo_search <= 1'b1; end
    @(posedge clk) begin irq <= 1'b1; wr <= 1'b1; lpon <= 1'b1; txw <= 1'b1; end
    @(posedge clk) begin irq <= 1'b0; wr <= 1'b0; txw <= 1'b0; end
    // Settling pause before relying on restored modules
    repeat (4) @(posedge clk);
    repeat (3000) rand_cycle();
    @(posedge clk) begin rst_n <= 1'b0; wr <= 1'b0; end
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3000) rand_cycle();
    complete_run();
  end

  // Watchdog well past the expected run length
  initial begin
    #200000;
    bad_count++;
    complete_run();
  end
endmodule : module_power_gating_control_tb

`default_nettype wire
